// ### shared/zcd_pkg.sv
package zcd_pkg;

  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_TIMER_B_MODE   = 8'h09;
  localparam logic [7:0] IDX_IRQ_EDGE_MODE  = 8'h10;
  localparam logic [7:0] IDX_PORT_MODE_B    = 8'h11;
  localparam logic [7:0] IDX_IRQ_STATUS     = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK       = 8'h21;
  localparam logic [7:0] IDX_PORT_BIT       = 8'h22;

  // Reset values
  localparam logic [3:0] RST_TIMER_B_MODE   = 4'h0;
  localparam logic [3:0] RST_IRQ_EDGE_MODE  = 4'h0;
  localparam logic [3:0] RST_PORT_MODE_B    = 4'h0;
  localparam logic [3:0] RST_IRQ_STATUS     = 4'h0;
  localparam logic [3:0] RST_IRQ_MASK       = 4'h0;
  localparam logic [1:0] RST_PORT_BIT       = 2'h0;

  // Pin function codes in port mode B bits 1..0
  localparam logic [1:0] PMB_ZC_LOW         = 2'h0;
  localparam logic [1:0] PMB_ZC_HIGH        = 2'h1;
  localparam logic [1:0] PMB_PORT           = 2'h2;
  localparam logic [1:0] PMB_EVENT          = 2'h3;

  // Field positions
  localparam int         TMB_SRC_MSB        = 2;
  localparam logic [2:0] TMB_SRC_EXT        = 3'h7;
  localparam int         IEM_RISE_POS       = 0;
  localparam int         IEM_BOTH_POS       = 1;
  localparam int         STAT_ZC_POS        = 0;
  localparam int         PORT_DATA_POS      = 0;
  localparam int         PORT_DIR_POS       = 1;
  localparam int         PORT_PIN_POS       = 2;

  // Synchroniser channels
  localparam int         CH_COMP            = 0;
  localparam int         CH_PIN             = 1;
  localparam int         NUM_CH             = 2;

endpackage

// ### shared/zcd_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
interface zcd_edge_if #(
  parameter int N = 2
);
  logic [N-1:0] raw;
  logic [N-1:0] level;
  logic [N-1:0] rise;
  logic [N-1:0] fall;

  modport sync_side (input raw, output level, output rise, output fall);
  modport user_side (output raw, input level, input rise, input fall);
endinterface
`default_nettype wire

// ### logic/zcd_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
module zcd_edge_sync #(
  parameter int N = 2
) (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  // Channels
  zcd_edge_if.sync_side ch
);

  logic [N-1:0] meta_ff;
  logic [N-1:0] sync_ff;
  logic [N-1:0] prev_ff;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_ch
      // Two-flop sync then edge
      always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          meta_ff[g] <= 1'b0;
          sync_ff[g] <= 1'b0;
          prev_ff[g] <= 1'b0;
        end else begin
          meta_ff[g] <= ch.raw[g];
          sync_ff[g] <= meta_ff[g];
          prev_ff[g] <= sync_ff[g];
        end
      end
      assign ch.level[g] = sync_ff[g];
      assign ch.rise[g]  = sync_ff[g] & ~prev_ff[g];
      assign ch.fall[g]  = ~sync_ff[g] & prev_ff[g];
    end
  endgenerate

endmodule
`default_nettype wire

// ### logic/zcd_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module zcd_ctrl (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Analog front end
  input  wire logic        zc_comp_i,
  output logic             zc_bias_en_o,
  output logic             zc_high_sens_o,
  output logic             zc_square_o,
  // Shared pin
  input  wire logic        general_port_bit8_i,
  output logic             general_port_bit8_o,
  output logic             general_port_bit8_oe_o,
  // MCU mode
  input  wire logic        subactive_i,
  // Timer B event clock
  output logic             timer_b_tick_o,
  // Interrupt
  output logic             irq_o
);

  logic [3:0] timer_b_mode_ff;
  logic [3:0] interrupt_edge_mode_ff;
  logic [3:0] port_mode_b_ff;
  logic [3:0] irq_status_ff;
  logic [3:0] irq_mask_ff;
  logic [1:0] port_bit_ff;
  logic       square_ff;
  logic       tick_ff;
  logic [31:0] prdata_ff;
  logic [3:0] nxt_irq_status;

  zcd_edge_if #(.N(zcd_pkg::NUM_CH)) edges ();

  // Comparator and pin both come from outside the clock domain
  assign edges.raw[zcd_pkg::CH_COMP] = zc_comp_i;
  assign edges.raw[zcd_pkg::CH_PIN]  = general_port_bit8_i;

  zcd_edge_sync #(
    .N (zcd_pkg::NUM_CH)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .ch        (edges.sync_side)
  );

  // Bus decode
  wire logic [7:0] reg_idx   = paddr_i[9:2];
  wire logic       addr_hi0  = (paddr_i[11:10] == 2'h0) && (paddr_i[1:0] == 2'h0);
  wire logic       hit_tmb   = addr_hi0 && (reg_idx == zcd_pkg::IDX_TIMER_B_MODE);
  wire logic       hit_iem   = addr_hi0 && (reg_idx == zcd_pkg::IDX_IRQ_EDGE_MODE);
  wire logic       hit_pmb   = addr_hi0 && (reg_idx == zcd_pkg::IDX_PORT_MODE_B);
  wire logic       hit_stat  = addr_hi0 && (reg_idx == zcd_pkg::IDX_IRQ_STATUS);
  wire logic       hit_mask  = addr_hi0 && (reg_idx == zcd_pkg::IDX_IRQ_MASK);
  wire logic       hit_port  = addr_hi0 && (reg_idx == zcd_pkg::IDX_PORT_BIT);
  wire logic       hit_any   = hit_tmb | hit_iem | hit_pmb | hit_stat | hit_mask | hit_port;
  wire logic       acc       = psel_i & penable_i;
  wire logic       wr_en     = acc & pwrite_i & pstrb_i[0];
  wire logic       setup_rd  = psel_i & ~penable_i & ~pwrite_i;

  wire logic [1:0] pin_fn    = port_mode_b_ff[1:0];
  wire logic       fn_detect = (pin_fn == zcd_pkg::PMB_ZC_LOW) || (pin_fn == zcd_pkg::PMB_ZC_HIGH);
  wire logic       fn_port   = (pin_fn == zcd_pkg::PMB_PORT);
  wire logic       fn_event  = (pin_fn == zcd_pkg::PMB_EVENT);

  wire logic       high_req  = (pin_fn == zcd_pkg::PMB_ZC_HIGH);

  wire logic       edge_rise = interrupt_edge_mode_ff[zcd_pkg::IEM_RISE_POS];
  wire logic       edge_both = interrupt_edge_mode_ff[zcd_pkg::IEM_BOTH_POS];
  wire logic       zc_rise   = edges.rise[zcd_pkg::CH_COMP];
  wire logic       zc_fall   = edges.fall[zcd_pkg::CH_COMP];
  wire logic       zc_event  = fn_detect &&
                               (edge_both ? (zc_rise | zc_fall) : (edge_rise ? zc_rise : zc_fall));

  wire logic       tmb_ext   = (timer_b_mode_ff[zcd_pkg::TMB_SRC_MSB:0] == zcd_pkg::TMB_SRC_EXT);
  wire logic       evt_fall  = edges.fall[zcd_pkg::CH_PIN];
  wire logic       nxt_tick  = tmb_ext && ((fn_detect && zc_rise) || (fn_event && evt_fall));

  // Status clear by writing one
  wire logic [3:0] stat_clr  = (wr_en && hit_stat) ? pwdata_i[3:0] : 4'h0;

  always_comb begin
    nxt_irq_status = irq_status_ff & ~stat_clr;
    if (zc_event) begin
      nxt_irq_status[zcd_pkg::STAT_ZC_POS] = 1'b1;
    end
  end

  // Read mux
  wire logic [3:0] rd_port   = {1'b0, edges.level[zcd_pkg::CH_PIN], port_bit_ff};
  wire logic [3:0] rd_val    = hit_iem  ? interrupt_edge_mode_ff :
                               hit_stat ? irq_status_ff :
                               hit_mask ? irq_mask_ff :
                               hit_port ? rd_port : 4'h0;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_mode_b_ff <= zcd_pkg::RST_PORT_MODE_B;
    end else if (wr_en && hit_pmb) begin
      port_mode_b_ff <= pwdata_i[3:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timer_b_mode_ff <= zcd_pkg::RST_TIMER_B_MODE;
    end else if (wr_en && hit_tmb) begin
      timer_b_mode_ff <= pwdata_i[3:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      interrupt_edge_mode_ff <= zcd_pkg::RST_IRQ_EDGE_MODE;
    end else if (wr_en && hit_iem) begin
      interrupt_edge_mode_ff <= pwdata_i[3:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_mask_ff <= zcd_pkg::RST_IRQ_MASK;
    end else if (wr_en && hit_mask) begin
      irq_mask_ff <= pwdata_i[3:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_bit_ff <= zcd_pkg::RST_PORT_BIT;
    end else if (wr_en && hit_port) begin
      port_bit_ff <= pwdata_i[1:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_status_ff <= zcd_pkg::RST_IRQ_STATUS;
    end else begin
      irq_status_ff <= nxt_irq_status;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      square_ff <= 1'b0;
      tick_ff   <= 1'b0;
    end else begin
      square_ff <= edges.level[zcd_pkg::CH_COMP] & fn_detect;
      tick_ff   <= nxt_tick;
    end
  end

  // Read data taken in setup, held through access
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_ff <= 32'h0;
    end else if (setup_rd) begin
      prdata_ff <= {28'h0, rd_val};
    end
  end

  // Outputs
  assign prdata_o               = prdata_ff;
  assign pready_o               = 1'b1;
  assign pslverr_o              = acc & ~hit_any;
  assign zc_bias_en_o           = fn_detect;
  assign zc_high_sens_o         = high_req & ~subactive_i;
  assign zc_square_o            = square_ff;
  assign general_port_bit8_o    = port_bit_ff[zcd_pkg::PORT_DATA_POS];
  assign general_port_bit8_oe_o = fn_port & port_bit_ff[zcd_pkg::PORT_DIR_POS];
  assign timer_b_tick_o         = tick_ff;
  assign irq_o                  = |(irq_status_ff & irq_mask_ff);

  // Checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  flag_set_edge_a: assert property (zc_event |=> irq_status_ff[zcd_pkg::STAT_ZC_POS])
    else $error("zero-cross flag not set after active edge");

  flag_quiet_a: assert property (!irq_status_ff[0] && !zc_event |=> !irq_status_ff[0])
    else $error("zero-cross flag set without active edge");

  flag_detect_a: assert property (!fn_detect && !irq_status_ff[0] |=> !irq_status_ff[0])
    else $error("zero-cross flag set outside detector function");

  flag_sticky_a: assert property (irq_status_ff[0] && !(wr_en && hit_stat && pwdata_i[0])
                                  |=> irq_status_ff[0])
    else $error("zero-cross flag dropped without clear");

  flag_clear_a: assert property (irq_status_ff[0] && wr_en && hit_stat && pwdata_i[0] && !zc_event
                                 |=> !irq_status_ff[0])
    else $error("zero-cross flag not cleared by write");

  edge_falling_a: assert property (fn_detect && !edge_both && !edge_rise && zc_rise |-> !zc_event)
    else $error("rising edge flagged in falling mode");

  edge_fall_set_a: assert property (fn_detect && !edge_both && !edge_rise && zc_fall
                                    |=> irq_status_ff[0])
    else $error("falling edge missed in falling mode");

  edge_rising_a: assert property (fn_detect && !edge_both && edge_rise && zc_fall |-> !zc_event)
    else $error("falling edge flagged in rising mode");

  edge_both_a: assert property (fn_detect && edge_both && zc_fall |=> irq_status_ff[0])
    else $error("falling edge missed in both-edge mode");

  sens_subact_a: assert property (subactive_i |-> !zc_high_sens_o)
    else $error("high sensitivity while subactive");

  sens_high_a: assert property ($rose(high_req) && !subactive_i |-> zc_high_sens_o)
    else $error("high sensitivity not applied");

  sens_detect_a: assert property (zc_high_sens_o |-> zc_bias_en_o)
    else $error("high sensitivity outside detector function");

  tmb_tick_a: assert property (tmb_ext && fn_detect && zc_rise |=> timer_b_tick_o)
    else $error("timer B tick missing on detector edge");

  tick_source_a: assert property (!tmb_ext |=> !timer_b_tick_o)
    else $error("timer B tick while internal source selected");

  tick_pulse_a: assert property (timer_b_tick_o && $stable(pin_fn) |=> !timer_b_tick_o)
    else $error("timer B tick longer than one cycle");

  tick_event_a: assert property (tmb_ext && fn_event && evt_fall |=> timer_b_tick_o)
    else $error("timer B tick missing on event pin edge");

  pin_port_a: assert property (general_port_bit8_oe_o |-> pin_fn == zcd_pkg::PMB_PORT && !zc_bias_en_o)
    else $error("pin driven outside port function");

  square_off_a: assert property (!fn_detect |=> !zc_square_o)
    else $error("square output active outside detector function");

  square_follow_a: assert property (fn_detect && $stable(fn_detect)
                                    |-> ##1 zc_square_o == $past(edges.level[0]))
    else $error("square output does not follow detector");

  square_rise_a: assert property (fn_detect && zc_rise |=> zc_square_o)
    else $error("square output missing after rising crossing");

  reset_mode_a: assert property ($rose(resetn_i) |-> zc_bias_en_o)
    else $error("detector not selected after reset");

  mode_hold_a: assert property (!(wr_en && hit_pmb) |=> $stable(port_mode_b_ff))
    else $error("pin function changed without write");

endmodule
`default_nettype wire

// ### tb/zcd_ac_model.sv
`timescale 1ns/1ps
`default_nettype none
module zcd_ac_model (
  // Clock
  input  wire logic       ref_clk_i,
  // Control
  input  wire logic       run_i,
  input  wire logic [7:0] half_i,
  // Comparator level
  output logic            wave_o
);
  logic [7:0] cnt_ff;
  logic       wave_ff = 1'b0;
  assign wave_o = wave_ff;
  // Flip at each zero crossing
  always @(posedge ref_clk_i) begin
    if (!run_i || cnt_ff == half_i) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
    if (run_i && cnt_ff == half_i) begin
      wave_ff <= ~wave_ff;
    end
  end
endmodule
`default_nettype wire

// ### tb/test_zero_crossing_detector_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_zero_crossing_detector_ctrl;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic        sub = 1'b0;
  logic        run = 1'b0;
  logic        pin = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        err;
  logic        pready, pslverr, comp, bias, hs, sq, pbo, pboe, tick, irq;
  int          fail_count = 0;
  int          total_checks = 0;

  zcd_ac_model i_zcd_ac_model (.ref_clk_i(clk), .run_i(run), .half_i(8'h13), .wave_o(comp));

  zcd_ctrl i_zcd_ctrl (
    .ref_clk_i(clk), .resetn_i(rstn), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .zc_comp_i(comp), .zc_bias_en_o(bias),
    .zc_high_sens_o(hs), .zc_square_o(sq), .general_port_bit8_i(pin),
    .general_port_bit8_o(pbo), .general_port_bit8_oe_o(pboe), .subactive_i(sub),
    .timer_b_tick_o(tick), .irq_o(irq));

  always #5 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic edge_wait(input logic up);
    if (up) @(posedge comp);
    else @(negedge comp);
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic t_reset;
    #1;
    chk(bias, 1'b1);
    chk(hs, 1'b0);
    chk(irq, 1'b0);
    chk(pready, 1'b1);
    apb(1'b0, zcd_pkg::IDX_IRQ_EDGE_MODE, 32'h0);
    chk(rd, zcd_pkg::RST_IRQ_EDGE_MODE);
    apb(1'b0, 8'h3f, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    $display("t_reset done");
  endtask

  task automatic t_modes;
    apb(1'b1, zcd_pkg::IDX_PORT_BIT, 32'h3);
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        @(posedge clk);
        sub <= s[0];
        apb(1'b1, zcd_pkg::IDX_PORT_MODE_B, m);
        #1;
        chk(bias, m < 2);
        chk(hs, m == 1 && s == 0);
        chk(pboe, m == 2);
        chk(pbo, 1'b1);
      end
    end
    apb(1'b0, zcd_pkg::IDX_PORT_MODE_B, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, zcd_pkg::IDX_PORT_MODE_B, zcd_pkg::PMB_ZC_LOW);
    $display("t_modes done");
  endtask

  task automatic t_irq;
    apb(1'b1, zcd_pkg::IDX_IRQ_EDGE_MODE, 32'h1);
    apb(1'b1, zcd_pkg::IDX_IRQ_MASK, 32'h1);
    apb(1'b1, zcd_pkg::IDX_IRQ_STATUS, 32'h1);
    run <= 1'b1;
    @(posedge comp);
    repeat (2) @(posedge clk);
    #1;
    chk(sq, 1'b0);
    chk(irq, 1'b0);
    @(posedge clk);
    #1;
    chk(sq, 1'b1);
    chk(irq, 1'b1);
    apb(1'b1, zcd_pkg::IDX_IRQ_STATUS, 32'h1);
    apb(1'b1, zcd_pkg::IDX_IRQ_EDGE_MODE, 32'h0);
    edge_wait(1'b0);
    chk(irq, 1'b1);
    apb(1'b1, zcd_pkg::IDX_IRQ_STATUS, 32'h1);
    apb(1'b1, zcd_pkg::IDX_IRQ_EDGE_MODE, 32'h2);
    edge_wait(1'b1);
    chk(irq, 1'b1);
    apb(1'b1, zcd_pkg::IDX_IRQ_MASK, 32'h0);
    #1;
    chk(irq, 1'b0);
    apb(1'b0, zcd_pkg::IDX_IRQ_STATUS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, zcd_pkg::IDX_IRQ_STATUS, 32'h1);
    apb(1'b0, zcd_pkg::IDX_IRQ_STATUS, 32'h0);
    chk(rd, 32'h0);
    $display("t_irq done");
  endtask

  task automatic t_timer;
    apb(1'b1, zcd_pkg::IDX_TIMER_B_MODE, 32'h7);
    edge_wait(1'b1);
    chk(tick, 1'b1);
    @(posedge clk);
    #1;
    chk(tick, 1'b0);
    apb(1'b0, zcd_pkg::IDX_TIMER_B_MODE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, zcd_pkg::IDX_PORT_MODE_B, zcd_pkg::PMB_EVENT);
    #1;
    chk(bias, 1'b0);
    @(posedge clk);
    pin <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk(sq, 1'b0);
    chk(tick, 1'b0);
    apb(1'b0, zcd_pkg::IDX_PORT_BIT, 32'h0);
    chk(rd, 32'h7);
    @(posedge clk);
    pin <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(tick, 1'b1);
    @(posedge clk);
    #1;
    chk(tick, 1'b0);
    $display("t_timer done");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset;
    t_modes;
    t_irq;
    t_timer;
    complete_run;
  end

  initial begin
    #200000;
    fail_count++;
    complete_run;
  end
endmodule
`default_nettype wire
